// ==== verilog/dsi_defs.vh ====
// register map, field layout and constants of the serial status and timer register group
`ifndef DSI_DEFS_VH
`define DSI_DEFS_VH
`define DSI_OFF_CHANGE 8'h00
`define DSI_OFF_AUX 8'h04
`define DSI_OFF_ISTAT 8'h08
`define DSI_OFF_IMASK 8'h0C
`define DSI_OFF_PREU 8'h10
`define DSI_OFF_PREL 8'h14
`define DSI_OFF_CNTU 8'h18
`define DSI_OFF_CNTL 8'h1C
`define DSI_OFF_SCRATCH 8'h20
`define DSI_OFF_LEVEL 8'h24
`define DSI_OFF_TXA 8'h28
`define DSI_OFF_TXB 8'h2C
`define DSI_OFF_CMDA 8'h30
`define DSI_OFF_CMDB 8'h34
`define DSI_OFF_START 8'h38
`define DSI_OFF_STOP 8'h3C
`define DSI_RST_BYTE 8'h00
`define DSI_RST_CNT 16'h0000
`define DSI_AUX_MODE 6
`define DSI_AUX_SRC_HI 5
`define DSI_AUX_SRC_LO 4
`define DSI_AUX_BAUD 7
`define DSI_IS_TXA 0
`define DSI_IS_RXA 1
`define DSI_IS_BRKA 2
`define DSI_IS_CT 3
`define DSI_IS_TXB 4
`define DSI_IS_RXB 5
`define DSI_IS_BRKB 6
`define DSI_IS_CHG 7
`define DSI_CMD_RST_TX 4'h3
`define DSI_CMD_RST_BRK 4'h5
`define DSI_SRC_IP2 2'h0
`define DSI_SRC_TXA 2'h1
`define DSI_SRC_TXB 2'h2
`define DSI_SRC_XD16 2'h3
`define DSI_TSRC_IP2 2'h0
`define DSI_TSRC_IP2D16 2'h1
`define DSI_TSRC_X 2'h2
`define DSI_TSRC_XD16 2'h3
`define DSI_DIV16_LAST 4'hF
`define DSI_FIFO_DEPTH 8
`define DSI_FIFO_CW 4
`define DSI_FIFO_AW 3
`define DSI_HTRANS_NONSEQ 2'b10
`endif

// ==== verilog/dsi_regs.v ====
// status, interrupt, counter/timer and transmit hand-off registers behind an ahb-lite slave
`timescale 1ns/1ps
`include "dsi_defs.vh"

// How it works
// - each channel keeps an 8-deep transmit fifo feeding its shift holding register
// - input_change_status bits 3:0 show present levels of inputs 3..0
// - bits 7:4 latch changes on inputs 3..0 and clear when that register is read
// - auxiliary_control bits 3:0 enable changes into status bit 7, reset disabled
// - auxiliary_control bits 6:4 choose counter or timer mode and its clock source
// - auxiliary_control bit 7 selects baud set 2; change only with channels idle
// - int_n is low when any status bit and its mask bit are both set
// - reading status clears nothing; each source clears its own way; reset clears bits 2, 3, 6 and 7
// - transmit ready is set while empty fifo places reach the trigger level
// - receive ready is set while the receive count reaches the trigger level
// - break change is set by break edges, cleared by command code 5
// - counter/timer ready sets at terminal count or rising timer output; stop clears
// - status bit 7 sets on enabled change and clears on input_change_status read
// - mask gates only int_n, not status readback or the ready outputs
// - the 16-bit preload is built from the upper and lower preload bytes
// - a counter start reloads the preload; preload writes wait for next start
// - count readback shows the live count; software reads it with counter stopped
// - in timer mode readback is zero and stop only clears the ready bit
// - a new preload reaches the timer at a start or after the running half-period ends
// - scratchpad_byte returns what was written and does nothing else
// - input_level shows inputs 6..0 in bits 6..0, bit 7 reads zero
module dsi_regs (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [6:0] mp_in,
  input wire tx1x_clk_a,
  input wire tx1x_clk_b,
  input wire tx_enable_a,
  input wire tx_enable_b,
  input wire [3:0] tx_trig_a,
  input wire [3:0] tx_trig_b,
  input wire tx_done_a,
  input wire tx_done_b,
  output reg [7:0] tx_char_a,
  output reg [7:0] tx_char_b,
  output reg tx_busy_a,
  output reg tx_busy_b,
  input wire [4:0] rx_count_a,
  input wire [4:0] rx_count_b,
  input wire [4:0] rx_trig_a,
  input wire [4:0] rx_trig_b,
  input wire break_edge_a,
  input wire break_edge_b,
  output wire int_n,
  output wire [3:0] ready_out_n,
  output reg ct_out,
  output wire baud_set2
);
  reg [7:0] aux_ff;
  reg [7:0] imask_ff;
  reg [7:0] preu_ff;
  reg [7:0] prel_ff;
  reg [7:0] scratch_ff;
  reg [3:0] chg_ff;
  reg ischg_ff;
  reg [1:0] brk_ff;
  reg isct_ff;
  reg [15:0] cnt_ff;
  reg run_ff;
  reg [6:0] sync1_ff;
  reg [6:0] sync2_ff;
  reg [3:0] prev_ff;
  reg ip2_prev_ff;
  reg txa_prev_ff;
  reg txb_prev_ff;
  reg [3:0] pre16_ff;
  reg [3:0] ip2div_ff;
  reg dph_ff;
  reg dwr_ff;
  reg [7:0] daddr_ff;
  reg rwait_ff;
  wire [7:0] istat;
  wire [3:0] chg_now;
  wire wr_go;
  wire rd_go;
  wire [7:0] wbyte;
  wire timer_mode;
  wire [1:0] src;
  wire [15:0] preload;
  wire ip2_rise;
  wire ip2d16_tick;
  wire x16_tick;
  wire [1:0] tx_ready;
  wire [1:0] wr_tx;
  wire [1:0] rst_tx;
  wire [1:0] take;
  wire [1:0] tx_en;
  wire [1:0] tx_done;
  wire [1:0] busy;
  wire [7:0] head [0:1];
  wire [3:0] trig [0:1];
  reg ct_tick;
  reg [31:0] rd_mux;
  reg [15:0] nxt_cnt;
  reg nxt_run;
  reg nxt_ct_out;
  reg nxt_isct;

  // bus: writes finish without wait, reads take one wait state so data comes from a flop
  assign hresp = 1'b0;
  assign hreadyout = ce & ~rwait_ff;
  assign wr_go = dph_ff & dwr_ff & ce;
  assign rd_go = rwait_ff & ce;
  assign wbyte = hwdata[7:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      dwr_ff <= 1'b0;
      daddr_ff <= `DSI_RST_BYTE;
      rwait_ff <= 1'b0;
    end else if (ce) begin
      if (hready) begin
        dph_ff <= hsel & (htrans == `DSI_HTRANS_NONSEQ);
        dwr_ff <= hwrite;
        daddr_ff <= haddr;
        rwait_ff <= hsel & (htrans == `DSI_HTRANS_NONSEQ) & ~hwrite;
      end else begin
        rwait_ff <= 1'b0;
      end
    end
  end

  // only the second stage feeds level and edge logic
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
      prev_ff <= 4'h0;
      ip2_prev_ff <= 1'b0;
      txa_prev_ff <= 1'b0;
      txb_prev_ff <= 1'b0;
    end else if (ce) begin
      sync1_ff <= mp_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff[3:0];
      ip2_prev_ff <= sync2_ff[2];
      txa_prev_ff <= tx1x_clk_a;
      txb_prev_ff <= tx1x_clk_b;
    end
  end
  assign chg_now = sync2_ff[3:0] ^ prev_ff;
  // a change landing in the read cycle survives the clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_ff <= 4'h0;
      ischg_ff <= 1'b0;
    end else if (ce) begin
      if (rd_go && daddr_ff == `DSI_OFF_CHANGE) begin
        chg_ff <= chg_now;
        ischg_ff <= |(chg_now & aux_ff[3:0]);
      end else begin
        chg_ff <= chg_ff | chg_now;
        ischg_ff <= ischg_ff | (|(chg_now & aux_ff[3:0]));
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_ff <= `DSI_RST_BYTE;
      imask_ff <= `DSI_RST_BYTE;
      preu_ff <= `DSI_RST_BYTE;
      prel_ff <= `DSI_RST_BYTE;
      scratch_ff <= `DSI_RST_BYTE;
    end else if (wr_go) begin
      case (daddr_ff)
        `DSI_OFF_AUX: aux_ff <= wbyte;
        `DSI_OFF_IMASK: imask_ff <= wbyte;
        `DSI_OFF_PREU: preu_ff <= wbyte;
        `DSI_OFF_PREL: prel_ff <= wbyte;
        `DSI_OFF_SCRATCH: scratch_ff <= wbyte;
        default: aux_ff <= aux_ff;
      endcase
    end
  end

  assign baud_set2 = aux_ff[`DSI_AUX_BAUD];
  assign preload = {preu_ff, prel_ff};
  assign wr_tx[0] = wr_go & (daddr_ff == `DSI_OFF_TXA);
  assign wr_tx[1] = wr_go & (daddr_ff == `DSI_OFF_TXB);
  assign rst_tx[0] = wr_go & (daddr_ff == `DSI_OFF_CMDA) & (wbyte[7:4] == `DSI_CMD_RST_TX);
  assign rst_tx[1] = wr_go & (daddr_ff == `DSI_OFF_CMDB) & (wbyte[7:4] == `DSI_CMD_RST_TX);
  assign tx_en = {tx_enable_b, tx_enable_a};
  assign tx_done = {tx_done_b, tx_done_a};
  assign busy = {tx_busy_b, tx_busy_a};
  assign trig[0] = tx_trig_a;
  assign trig[1] = tx_trig_b;

  // a write to a full fifo is dropped; the reset-transmitter command flushes it
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_tx
      reg [7:0] mem_ff [0:`DSI_FIFO_DEPTH-1];
      reg [`DSI_FIFO_AW-1:0] wp_ff;
      reg [`DSI_FIFO_AW-1:0] rp_ff;
      reg [`DSI_FIFO_CW-1:0] cnt_ff;
      wire full;
      wire push;
      assign full = (cnt_ff == `DSI_FIFO_DEPTH);
      assign push = wr_tx[ch] & ~full;
      assign take[ch] = tx_en[ch] & (~busy[ch] | tx_done[ch]) & (cnt_ff != 0) & ~rst_tx[ch];
      assign tx_ready[ch] = (`DSI_FIFO_DEPTH - cnt_ff >= trig[ch]);
      assign head[ch] = mem_ff[rp_ff];
      always @(posedge hclk) begin
        if (ce && push) begin
          mem_ff[wp_ff] <= wbyte;
        end
      end
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          wp_ff <= {`DSI_FIFO_AW{1'b0}};
          rp_ff <= {`DSI_FIFO_AW{1'b0}};
          cnt_ff <= {`DSI_FIFO_CW{1'b0}};
        end else if (ce) begin
          if (rst_tx[ch]) begin
            wp_ff <= {`DSI_FIFO_AW{1'b0}};
            rp_ff <= {`DSI_FIFO_AW{1'b0}};
            cnt_ff <= {`DSI_FIFO_CW{1'b0}};
          end else begin
            if (push) begin
              wp_ff <= wp_ff + 1'b1;
            end
            if (take[ch]) begin
              rp_ff <= rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + {3'b000, push} - {3'b000, take[ch]};
          end
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_char_a <= `DSI_RST_BYTE;
      tx_char_b <= `DSI_RST_BYTE;
      tx_busy_a <= 1'b0;
      tx_busy_b <= 1'b0;
    end else if (ce) begin
      if (take[0]) begin
        tx_char_a <= head[0];
      end
      if (take[1]) begin
        tx_char_b <= head[1];
      end
      tx_busy_a <= take[0] | (tx_busy_a & ~tx_done_a & ~rst_tx[0]);
      tx_busy_b <= take[1] | (tx_busy_b & ~tx_done_b & ~rst_tx[1]);
    end
  end

  // break-change flags: a break edge in the clear cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_ff <= 2'b00;
    end else if (ce) begin
      brk_ff[0] <= break_edge_a | (brk_ff[0] & ~(wr_go & daddr_ff == `DSI_OFF_CMDA
        & wbyte[7:4] == `DSI_CMD_RST_BRK));
      brk_ff[1] <= break_edge_b | (brk_ff[1] & ~(wr_go & daddr_ff == `DSI_OFF_CMDB
        & wbyte[7:4] == `DSI_CMD_RST_BRK));
    end
  end
  // counter/timer clock sources
  assign timer_mode = aux_ff[`DSI_AUX_MODE];
  assign src = aux_ff[`DSI_AUX_SRC_HI:`DSI_AUX_SRC_LO];
  assign ip2_rise = sync2_ff[2] & ~ip2_prev_ff;
  assign x16_tick = (pre16_ff == `DSI_DIV16_LAST);
  assign ip2d16_tick = ip2_rise & (ip2div_ff == `DSI_DIV16_LAST);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre16_ff <= 4'h0;
      ip2div_ff <= 4'h0;
    end else if (ce) begin
      pre16_ff <= pre16_ff + 1'b1;
      if (ip2_rise) begin
        ip2div_ff <= ip2div_ff + 1'b1;
      end
    end
  end
  always @* begin
    ct_tick = 1'b0;
    case ({timer_mode, src})
      {1'b0, `DSI_SRC_IP2}: ct_tick = ip2_rise;
      {1'b0, `DSI_SRC_TXA}: ct_tick = tx1x_clk_a & ~txa_prev_ff;
      {1'b0, `DSI_SRC_TXB}: ct_tick = tx1x_clk_b & ~txb_prev_ff;
      {1'b0, `DSI_SRC_XD16}: ct_tick = x16_tick;
      {1'b1, `DSI_TSRC_IP2}: ct_tick = ip2_rise;
      {1'b1, `DSI_TSRC_IP2D16}: ct_tick = ip2d16_tick;
      {1'b1, `DSI_TSRC_X}: ct_tick = 1'b1;
      {1'b1, `DSI_TSRC_XD16}: ct_tick = x16_tick;
      default: ct_tick = 1'b0;
    endcase
  end
  // mode field is not guarded: changing it mid-run is left to software
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_ct_out = ct_out;
    nxt_isct = isct_ff;
    if (rd_go && daddr_ff == `DSI_OFF_STOP) begin
      nxt_isct = 1'b0;
      if (!timer_mode) begin
        nxt_run = 1'b0;
        nxt_ct_out = 1'b1;
      end
    end
    if (rd_go && daddr_ff == `DSI_OFF_START) begin
      nxt_cnt = preload;
      nxt_run = 1'b1;
      nxt_ct_out = 1'b1;
    end else if (run_ff && ct_tick) begin
      if (!timer_mode) begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == 16'h0001) begin
          nxt_isct = 1'b1;
          nxt_ct_out = 1'b0;
        end
      end else if (cnt_ff <= 16'h0001) begin
        nxt_cnt = preload;
        nxt_ct_out = ~ct_out;
        if (!ct_out) begin
          nxt_isct = 1'b1;
        end
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= `DSI_RST_CNT;
      run_ff <= 1'b0;
      ct_out <= 1'b1;
      isct_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      ct_out <= nxt_ct_out;
      isct_ff <= nxt_isct;
    end
  end
  // status is raw; masking happens only at int_n
  assign istat[`DSI_IS_TXA] = tx_ready[0];
  assign istat[`DSI_IS_RXA] = (rx_count_a >= rx_trig_a);
  assign istat[`DSI_IS_BRKA] = brk_ff[0];
  assign istat[`DSI_IS_CT] = isct_ff;
  assign istat[`DSI_IS_TXB] = tx_ready[1];
  assign istat[`DSI_IS_RXB] = (rx_count_b >= rx_trig_b);
  assign istat[`DSI_IS_BRKB] = brk_ff[1];
  assign istat[`DSI_IS_CHG] = ischg_ff;
  assign int_n = ~(|(istat & imask_ff));
  assign ready_out_n = ~{istat[`DSI_IS_TXB], istat[`DSI_IS_TXA], istat[`DSI_IS_RXB],
    istat[`DSI_IS_RXA]};

  always @* begin
    rd_mux = 32'h0000_0000;
    case (daddr_ff)
      `DSI_OFF_CHANGE: rd_mux[7:0] = {chg_ff, sync2_ff[3:0]};
      `DSI_OFF_AUX: rd_mux[7:0] = aux_ff;
      `DSI_OFF_ISTAT: rd_mux[7:0] = istat;
      `DSI_OFF_IMASK: rd_mux[7:0] = imask_ff;
      `DSI_OFF_PREU: rd_mux[7:0] = preu_ff;
      `DSI_OFF_PREL: rd_mux[7:0] = prel_ff;
      `DSI_OFF_CNTU: rd_mux[7:0] = timer_mode ? `DSI_RST_BYTE : cnt_ff[15:8];
      `DSI_OFF_CNTL: rd_mux[7:0] = timer_mode ? `DSI_RST_BYTE : cnt_ff[7:0];
      `DSI_OFF_SCRATCH: rd_mux[7:0] = scratch_ff;
      `DSI_OFF_LEVEL: rd_mux[7:0] = {1'b0, sync2_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata <= rd_mux;
    end
  end
endmodule // dsi_regs

// ==== verification/dsi_chk.sv ====
// concurrent checks on the ports of the status and timer register block
`timescale 1ns/1ps
module dsi_chk (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire [4:0] rx_count_a,
  input wire [4:0] rx_trig_a,
  input wire [4:0] rx_count_b,
  input wire [4:0] rx_trig_b,
  input wire [3:0] ready_out_n,
  input wire tx_enable_a,
  input wire tx_done_a,
  input wire tx_busy_a,
  input wire [7:0] tx_char_a,
  input wire baud_set2
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_go = ce && hready && hsel && htrans == 2'h2 && !hwrite;
  wire wr_go = ce && hready && hsel && htrans == 2'h2 && hwrite;
  // a read always inserts exactly one wait state
  read_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_now_a: assert property (wr_go |=> hreadyout)
    else $error("write stalled");
  baud_sel_a: assert property (
    wr_go && haddr == 8'h04 ##1 1'b1 |=> baud_set2 == $past(hwdata[7]))
    else $error("baud select not taken from write");
  level_top_a: assert property (
    rd_go && haddr == 8'h24 |-> ##2 hrdata[31:7] == 25'h000_0000)
    else $error("input level top bits not zero");
  rx_set_a: assert property (
    (ce && rx_count_a >= rx_trig_a) [*3] |-> !ready_out_n[0])
    else $error("receive ready a missing");
  rx_clear_a: assert property (
    (ce && rx_count_b < rx_trig_b) [*3] |-> ready_out_n[1])
    else $error("receive ready b stuck");
  tx_take_a: assert property ($rose(tx_busy_a) |-> $past(tx_enable_a))
    else $error("char taken while disabled");
  tx_hold_a: assert property (
    tx_busy_a && $past(tx_busy_a) && !$past(tx_done_a) |-> $stable(tx_char_a))
    else $error("char changed while busy");
endmodule // dsi_chk

bind dsi_regs dsi_chk u_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hrdata, .rx_count_a, .rx_trig_a, .rx_count_b, .rx_trig_b,
  .ready_out_n, .tx_enable_a, .tx_done_a, .tx_busy_a, .tx_char_a, .baud_set2);

// ==== verification/dsi_host.sv ====
// host processor model driving single word transfers on the register bus
`timescale 1ns/1ps
module dsi_host (
  input wire hclk,
  input wire hready,
  input wire [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  bit tmo = 0;
  initial begin
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
  end
  // hready only moves at rising edges, so the mid-cycle look equals the edge sample
  task wt;
    int n;
    n = 0;
    @(negedge hclk);
    while (!hready && n < 50) begin
      @(negedge hclk);
      n++;
    end
    if (!hready) tmo = 1;
    @(posedge hclk);
  endtask
  task xf(input [7:0] a, input w, input [7:0] d, output [7:0] q);
    @(posedge hclk);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel <= 0;
    htrans <= 0;
    hwdata <= {24'h00_0000, d};
    wt;
    q = hrdata[7:0];
  endtask
endmodule // dsi_host

// ==== verification/test_duart_status_interrupt_and_timer_regs.sv ====
// self-checking bench for the status, interrupt and timer register block
`timescale 1ns/1ps
module test_duart_status_interrupt_and_timer_regs;
  logic hclk = 0, hresetn = 0, ce = 1, hready, hreadyout, hresp, int_n, ct_out, baud_set2;
  logic hsel, hwrite, tx_busy_a, tx_busy_b;
  logic [7:0] haddr, tx_char_a, tx_char_b, q, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [6:0] mp_in = 0;
  logic tx1x_clk_a = 0, tx1x_clk_b = 0, tx_enable_a = 0, tx_enable_b = 0;
  logic tx_done_a = 0, tx_done_b = 0, break_edge_a = 0, break_edge_b = 0;
  logic [3:0] tx_trig_a = 4, tx_trig_b = 4, ready_out_n, old, c;
  logic [4:0] rx_count_a = 0, rx_count_b = 0, rx_trig_a = 1, rx_trig_b = 1;
  logic [7:0] txq[$];
  logic [7:0] rwa[5] = '{8'h0C, 8'h10, 8'h14, 8'h20, 8'h04};
  logic [7:0] mds[6] = '{8'h00, 8'h20, 8'h30, 8'h40, 8'h50, 8'h70};
  int fail_count = 0, total_checks = 0, n;
  logic [31:0] seed = 32'h149f_5ee4;
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  dsi_regs u_dsi_regs (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .mp_in, .tx1x_clk_a, .tx1x_clk_b,
    .tx_enable_a, .tx_enable_b, .tx_trig_a, .tx_trig_b, .tx_done_a, .tx_done_b, .tx_char_a,
    .tx_char_b, .tx_busy_a, .tx_busy_b, .rx_count_a, .rx_count_b, .rx_trig_a, .rx_trig_b,
    .break_edge_a, .break_edge_b, .int_n, .ready_out_n, .ct_out, .baud_set2);
  dsi_host h (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    h.xf(a, 1'b1, d, q);
    if (h.tmo) close_out;
  endtask
  task go(input [7:0] a);
    h.xf(a, 1'b0, 8'h00, q);
    if (h.tmo) close_out;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    h.xf(a, 1'b0, 8'h00, q);
    if (h.tmo) close_out;
    chk($sformatf("reg %h", a), {24'h00_0000, e}, hrdata);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task tick;
    @(posedge hclk);
    tx1x_clk_a <= 1;
    cyc(3);
    tx1x_clk_a <= 0;
    cyc(3);
  endtask
  // 32 slow pulses on input 2 and the channel b 1x clock, each seen once, input 2 after sync and the 1x clock unsynchronized
  task pulses;
    repeat (32) begin
      @(posedge hclk);
      mp_in[2] <= 1'b1;
      tx1x_clk_b <= 1'b1;
      cyc(3);
      mp_in[2] <= 1'b0;
      tx1x_clk_b <= 1'b0;
      cyc(2);
    end
  endtask
  task close_out;
    if (h.tmo) fail_count++;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #6000000;
    fail_count++;
    close_out;
  end
  initial begin
    cyc(10);
    hresetn <= 1;
    for (int a = 0; a <= 36; a += 4) rd(a[7:0], a == 8 ? 8'h11 : 8'h00);
    $display("test reset done");
    foreach (rwa[i]) begin
      v = rnd();
      wr(rwa[i], v);
      rd(rwa[i], v);
    end
    chk("baud", v[7], baud_set2);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    wr(8'h24, 8'hFF);
    rd(8'h24, 8'h00);
    repeat (4) begin
      v = rnd();
      wr(8'h0C, v);
      cyc(1);
      chk("int_n", ~|(v & 8'h11), int_n);
    end
    $display("test registers done");
    wr(8'h04, 8'h0F);
    wr(8'h0C, 8'h80);
    old = 0;
    repeat (6) begin
      v = rnd();
      mp_in <= v[6:0];
      cyc(4);
      c = old ^ v[3:0];
      rd(8'h24, {1'b0, v[6:0]});
      rd(8'h08, {|c, 7'h11});
      chk("int_n", ~|c, int_n);
      rd(8'h00, {c, v[3:0]});
      rd(8'h00, {4'h0, v[3:0]});
      rd(8'h08, 8'h11);
      old = v[3:0];
    end
    $display("test inputs done");
    wr(8'h0C, 8'h44);
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      break_edge_a <= (i == 0);
      break_edge_b <= (i == 1);
      @(posedge hclk);
      break_edge_a <= 0;
      break_edge_b <= 0;
      rd(8'h08, i ? 8'h51 : 8'h15);
      rd(8'h08, i ? 8'h51 : 8'h15);
      chk("int_n", 0, int_n);
      wr(i ? 8'h34 : 8'h30, 8'h50);
      rd(8'h08, 8'h11);
    end
    v = rnd();
    rx_trig_a <= {1'b0, v[3:0]} + 5'h1;
    rx_count_a <= {1'b0, v[3:0]} + 5'h1;
    rx_trig_b <= 5'h10;
    rx_count_b <= 5'h10;
    rd(8'h08, 8'h33);
    chk("ready_out_n", 4'h0, ready_out_n);
    rx_count_a <= {1'b0, v[3:0]};
    rx_count_b <= 5'h0F;
    rd(8'h08, 8'h11);
    chk("ready_out_n", 4'h3, ready_out_n);
    $display("test status done");
    wr(8'h04, 8'h10);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h03);
    go(8'h38);
    repeat (2) tick;
    rd(8'h08, 8'h11);
    chk("ct_out", 1, ct_out);
    tick;
    rd(8'h08, 8'h19);
    chk("ct_out", 0, ct_out);
    wr(8'h14, 8'h05);
    go(8'h3C);
    rd(8'h08, 8'h11);
    chk("ct_out", 1, ct_out);
    rd(8'h18, 8'h00);
    rd(8'h1C, 8'h00);
    go(8'h38);
    // a tick while the clock enable is low must not move the count
    ce <= 0;
    tick;
    ce <= 1;
    go(8'h3C);
    rd(8'h1C, 8'h05);
    $display("test counter done");
    wr(8'h04, 8'h60);
    wr(8'h10, 8'h01);
    wr(8'h14, 8'h00);
    go(8'h38);
    rd(8'h1C, 8'h00);
    cyc(600);
    rd(8'h08, 8'h19);
    go(8'h3C);
    rd(8'h08, 8'h11);
    v[0] = ct_out;
    n = 0;
    while (ct_out === v[0] && n < 600) begin
      cyc(1);
      n++;
    end
    chk("timer runs", 1, n < 600);
    // back to a stopped counter so the ready bit stays quiet below
    wr(8'h04, 8'h00);
    go(8'h3C);
    $display("test timer done");
    // every remaining source code: preload 1 reaches ready within two ticks
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h01);
    foreach (mds[i]) begin
      wr(8'h04, mds[i]);
      go(8'h38);
      pulses;
      rd(8'h08, 8'h19);
      go(8'h3C);
      wr(8'h04, 8'h00);
      go(8'h3C);
      rd(8'h08, 8'h11);
    end
    $display("test sources done");
    repeat (9) begin
      v = rnd();
      wr(8'h28, v);
      if (txq.size() < 8) txq.push_back(v);
    end
    rd(8'h08, 8'h10);
    tx_trig_a <= 0;
    rd(8'h08, 8'h11);
    tx_enable_a <= 1;
    repeat (8) begin
      cyc(3);
      chk("tx_busy_a", 1, tx_busy_a);
      chk("tx_char_a", txq.pop_front(), tx_char_a);
      tx_done_a <= 1;
      cyc(1);
      tx_done_a <= 0;
    end
    cyc(3);
    chk("tx_busy_a", 0, tx_busy_a);
    tx_enable_b <= 1;
    v = rnd();
    wr(8'h2C, v);
    cyc(3);
    chk("tx_char_b", v, tx_char_b);
    // reset-transmitter command flushes the waiting characters
    tx_enable_a <= 0;
    tx_trig_a <= 8;
    repeat (3) wr(8'h28, v);
    rd(8'h08, 8'h10);
    wr(8'h30, 8'h30);
    rd(8'h08, 8'h11);
    tx_enable_a <= 1;
    cyc(3);
    chk("tx_busy_a", 0, tx_busy_a);
    $display("test transmit done");
    close_out;
  end
endmodule // test_duart_status_interrupt_and_timer_regs
